// [rtl/tsic_pkg.sv]
/*
 Package for the three-source interrupt controller: register offsets, field
 positions, reset values, edge-select codes and shared structs.
 Assumes an 8-bit register space reached over a 32-bit Avalon-MM slave.
*/
package tsic_pkg;

    // ==================================================================
    // Register map (printed offsets are not word aligned: they are indices)
    localparam logic [7:0] IDX_EDGE_SELECT  = 8'hbf;
    localparam logic [7:0] IDX_IRQ_REQUEST  = 8'hc8;
    localparam logic [7:0] IDX_IRQ_ENABLE   = 8'hc9;
    localparam logic [7:0] IDX_STACK_GIE    = 8'hdf;
    localparam logic [7:0] IDX_CORE_CTRL    = 8'he8;
    localparam logic [7:0] IDX_CORE_STATUS  = 8'he9;
    localparam logic [7:0] IDX_SAVE_ACC     = 8'hea;
    localparam logic [7:0] IDX_SAVE_FLAGS   = 8'heb;
    localparam int         ADDR_W           = 10;

    // ==================================================================
    // Field positions
    localparam int BIT_EXT_PIN   = 0;
    localparam int BIT_TIMER_A   = 4;
    localparam int BIT_TIMER_B   = 5;
    localparam int BIT_GIE       = 7;
    localparam int EDGE_LO       = 3;
    localparam int EDGE_HI       = 4;
    localparam int BIT_TIMEOUT   = 4;
    localparam int BIT_PWRDN     = 3;

    // Core control bits (write 1 to act)
    localparam int CTRL_ENTER    = 0;
    localparam int CTRL_RETURN   = 1;
    localparam int CTRL_SAVE     = 2;
    localparam int CTRL_RESTORE  = 3;
    localparam int CTRL_SLEEP    = 4;

    // ==================================================================
    // Reset values and masks
    localparam logic [7:0] RST_EDGE_SELECT = 8'h10;
    localparam logic [7:0] RST_IRQ_ENABLE  = 8'h00;
    localparam logic [7:0] RST_IRQ_REQUEST = 8'h00;
    localparam logic [1:0] RST_STACK_LVL   = 2'h3;
    localparam logic [7:0] MASK_IRQ        = 8'h31;
    localparam logic [7:0] MASK_EDGE       = 8'h18;
    localparam logic [7:0] MASK_FLAGS_SAVE = 8'he7;
    localparam logic [11:0] VECTOR_ADDR    = 12'h008;
    localparam logic [31:0] READ_UNMAPPED  = 32'h0000_0000;

    typedef enum logic [1:0] {
        EDGE_RESERVED = 2'b00,
        EDGE_RISING   = 2'b01,
        EDGE_FALLING  = 2'b10,
        EDGE_BOTH     = 2'b11
    } tsic_edge_e;

    typedef struct packed {
        logic timerB;
        logic timerA;
        logic extPin;
    } tsic_src_s;

    typedef struct packed {
        logic        takeIrq;
        logic        leaveIrq;
        logic [11:0] vector;
    } tsic_core_s;

endpackage

// [rtl/tsic_pin_edge.sv]
/*
 External pin edge detector with three-stage synchroniser.
 Assumes an asynchronous pin; the second and third stages must agree.
*/
`timescale 1ns/10ps
module tsic_pin_edge (
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire logic              pinIn,
    input  wire tsic_pkg::tsic_edge_e edgeSel,
    output logic                   edgeHit,
    output logic                   pinLevel
);
    logic sync1;
    logic sync2;
    logic sync3;

    // ==================================================================
    // Synchroniser
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            sync3 <= 1'b1;
        end else begin
            sync1 <= pinIn;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // ==================================================================
    // Stable level and edge decode
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pinLevel <= 1'b1;
            edgeHit  <= 1'b0;
        end else begin
            edgeHit <= 1'b0;
            if (sync2 == sync3 && sync3 != pinLevel) begin
                pinLevel <= sync3;
                unique case (edgeSel)
                    tsic_pkg::EDGE_RISING:   edgeHit <= sync3;
                    tsic_pkg::EDGE_FALLING:  edgeHit <= !sync3;
                    tsic_pkg::EDGE_BOTH:     edgeHit <= 1'b1;
                    tsic_pkg::EDGE_RESERVED: edgeHit <= 1'b0;
                endcase
            end
        end
    end
endmodule // tsic_pin_edge

// [rtl/tsic_save_buf.sv]
/*
 Single-level save buffer for accumulator and processor flags.
 Assumes save and restore strobes are one-cycle pulses from the same clock.
*/
`timescale 1ns/10ps
module tsic_save_buf (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       saveStb,
    input  wire logic [7:0] accIn,
    input  wire logic [7:0] flagsIn,
    output logic      [7:0] accSaved,
    output logic      [7:0] flagsSaved
);
    // ==================================================================
    // One level only; timeout and power-down bits are never stored
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            accSaved   <= 8'h00;
            flagsSaved <= 8'h00;
        end else if (saveStb) begin
            accSaved   <= accIn;
            flagsSaved <= flagsIn & tsic_pkg::MASK_FLAGS_SAVE;
        end
    end
endmodule // tsic_save_buf

// [rtl/tsic_irq_ctrl.sv]
/*
 Top of the three-source interrupt controller: request flags, enables,
 global enable with stack level, vectoring to the core, save buffer and
 power-down wake by the external pin. Avalon-MM slave with waitrequest.
 Assumes the core raises instrBoundary once per instruction and reports
 the return-from-interrupt instruction on retiExec.
*/
// What this block does
// - Three sources: timer A, timer B, pin
// - Entering service clears global enable
// - Leaving service sets global enable again
// - Enables at bits 0,4,5; reset zero
// - Entry pushes return, adds level, vector 8
// - Return instruction pops address and resumes
// - Hardware sets flags; only software clears
// - Flags at bits 0,4,5; reset zero
// - Service needs global enable bit 7; reset 0
// - Pin edge sets flag regardless of enable
// - Enabled pin edge vectors to 8
// - Matching wake edge latched, no priority over timers
// - Edge select bits 4:3, reset falling
// - Timer A overflow always sets flag
// - Timer A vectors only when enabled
// - Timer B overflow always sets flag
// - Disabled timer B never vectors alone
// - One-level save buffer, timeout/powerdown excluded
// - Pin edge wakes from power-down
`timescale 1ns/10ps
module tsic_irq_ctrl (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        extIrqInput,
    input  wire logic        timerAOverflow,
    input  wire logic        timerBOverflow,
    input  wire logic        instrBoundary,
    input  wire logic        retiExec,
    input  wire logic [11:0] returnAddr,
    input  wire logic [7:0]  accIn,
    input  wire logic [7:0]  procFlagsIn,
    output logic             takeIrq,
    output logic      [11:0] vectorAddr,
    output logic      [11:0] popAddr,
    output logic             resumeStb,
    output logic             powerDown,
    output logic             wakeStb,
    output logic      [7:0]  accRestore,
    output logic      [7:0]  procFlagsRestore,
    output logic             restoreStb
);
    logic [7:0]           edgeSelect;
    logic [7:0]           irqEnable;
    logic [7:0]           irqRequest;
    logic                 globalIrqEnable;
    logic [1:0]           stackLevel;
    logic [11:0]          retStack [4];
    logic                 inService;
    logic                 wakeLatch;
    logic                 pinEdge;
    logic                 pinLevel;
    logic                 busAck;
    logic                 wrHit;
    logic                 rdHit;
    logic [7:0]           regIndex;
    logic [7:0]           wrByte;
    logic [7:0]           accSaved;
    logic [7:0]           flagsSaved;
    logic                 ctrlWr;
    logic                 saveStb;
    logic                 pendingEnabled;
    logic                 enterNow;
    logic                 leaveNow;
    logic                 stackWr;
    logic [7:0]           next_irqRequest;
    tsic_pkg::tsic_src_s  srcEvent;
    tsic_pkg::tsic_edge_e edgeMode;

    // ==================================================================
    // Bus decode: one aligned word per register, index = byte address / 4
    assign regIndex = avs_address[9:2];
    assign wrByte   = avs_writedata[7:0];
    assign wrHit    = avs_write && !busAck && avs_byteenable[0];
    assign rdHit    = avs_read && !busAck;
    assign ctrlWr   = wrHit && regIndex == tsic_pkg::IDX_CORE_CTRL;
    assign saveStb  = ctrlWr && wrByte[tsic_pkg::CTRL_SAVE];
    assign edgeMode = tsic_pkg::tsic_edge_e'(edgeSelect[tsic_pkg::EDGE_HI:tsic_pkg::EDGE_LO]);

    // ==================================================================
    // Sources
    tsic_pin_edge u_pin_edge (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .pinIn    (extIrqInput),
        .edgeSel  (edgeMode),
        .edgeHit  (pinEdge),
        .pinLevel (pinLevel)
    );

    tsic_save_buf u_save_buf (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .saveStb    (saveStb),
        .accIn      (accIn),
        .flagsIn    (procFlagsIn),
        .accSaved   (accSaved),
        .flagsSaved (flagsSaved)
    );

    assign srcEvent.extPin = pinEdge;
    assign srcEvent.timerA = timerAOverflow;
    assign srcEvent.timerB = timerBOverflow;

    // Enabled and pending, OR of all sources with no priority
    assign pendingEnabled = |(irqEnable & irqRequest & tsic_pkg::MASK_IRQ);

    // ==================================================================
    // Bus handshake: one wait cycle, then acknowledge
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            busAck <= 1'b0;
        end else begin
            busAck <= (avs_read || avs_write) && !busAck;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && !busAck);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rdHit) begin
            unique case (regIndex)
                tsic_pkg::IDX_EDGE_SELECT: avs_readdata <= {24'h0, edgeSelect};
                tsic_pkg::IDX_IRQ_REQUEST: avs_readdata <= {24'h0, irqRequest};
                tsic_pkg::IDX_IRQ_ENABLE:  avs_readdata <= {24'h0, irqEnable};
                tsic_pkg::IDX_STACK_GIE:
                    avs_readdata <= {24'h0, globalIrqEnable, 5'h00, stackLevel};
                tsic_pkg::IDX_CORE_STATUS:
                    avs_readdata <= {24'h0, 5'h00, wakeLatch, pinLevel, inService};
                tsic_pkg::IDX_SAVE_ACC:    avs_readdata <= {24'h0, accSaved};
                tsic_pkg::IDX_SAVE_FLAGS:  avs_readdata <= {24'h0, flagsSaved};
                default:                   avs_readdata <= tsic_pkg::READ_UNMAPPED;
            endcase
        end
    end

    // ==================================================================
    // Edge select and enables
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            edgeSelect <= tsic_pkg::RST_EDGE_SELECT;
        end else if (wrHit && regIndex == tsic_pkg::IDX_EDGE_SELECT) begin
            edgeSelect <= wrByte & tsic_pkg::MASK_EDGE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            irqEnable <= tsic_pkg::RST_IRQ_ENABLE;
        end else if (wrHit && regIndex == tsic_pkg::IDX_IRQ_ENABLE) begin
            irqEnable <= wrByte & tsic_pkg::MASK_IRQ;
        end
    end

    // ==================================================================
    // Request flags: set wins over a software clear in the same cycle
    always_comb begin
        next_irqRequest = irqRequest;
        if (wrHit && regIndex == tsic_pkg::IDX_IRQ_REQUEST) begin
            next_irqRequest = wrByte & tsic_pkg::MASK_IRQ;
        end
        next_irqRequest[tsic_pkg::BIT_EXT_PIN] |= srcEvent.extPin;
        next_irqRequest[tsic_pkg::BIT_TIMER_A] |= srcEvent.timerA;
        next_irqRequest[tsic_pkg::BIT_TIMER_B] |= srcEvent.timerB;
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            irqRequest <= tsic_pkg::RST_IRQ_REQUEST;
        end else begin
            irqRequest <= next_irqRequest;
        end
    end

    // ==================================================================
    // Power-down and wake by the external pin
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            powerDown <= 1'b0;
            wakeStb   <= 1'b0;
            wakeLatch <= 1'b0;
        end else begin
            wakeStb <= 1'b0;
            if (powerDown && pinEdge) begin
                powerDown <= 1'b0;
                wakeStb   <= 1'b1;
                wakeLatch <= 1'b1;
            end else if (ctrlWr && wrByte[tsic_pkg::CTRL_SLEEP]) begin
                powerDown <= 1'b1;
            end else if (takeIrq) begin
                wakeLatch <= 1'b0;
            end
        end
    end

    // ==================================================================
    // Vectoring, stack and global enable; entry beats return beats a register write
    assign enterNow = !powerDown && !takeIrq && instrBoundary && globalIrqEnable
                      && pendingEnabled;
    assign leaveNow = inService && !enterNow
                      && (retiExec || (ctrlWr && wrByte[tsic_pkg::CTRL_RETURN]));
    assign stackWr  = wrHit && regIndex == tsic_pkg::IDX_STACK_GIE;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            takeIrq <= 1'b0;
        end else begin
            takeIrq <= enterNow;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            vectorAddr <= tsic_pkg::VECTOR_ADDR;
        end else if (enterNow) begin
            vectorAddr <= tsic_pkg::VECTOR_ADDR;
        end
    end

    // Return addresses; contents need no reset
    always_ff @(posedge clk_sys) begin
        if (enterNow) begin
            retStack[stackLevel + 2'd1] <= returnAddr;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            stackLevel <= tsic_pkg::RST_STACK_LVL;
        end else if (enterNow) begin
            stackLevel <= stackLevel + 2'd1;
        end else if (leaveNow) begin
            stackLevel <= stackLevel - 2'd1;
        end else if (stackWr) begin
            stackLevel <= wrByte[1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            globalIrqEnable <= 1'b0;
        end else if (enterNow) begin
            globalIrqEnable <= 1'b0;
        end else if (leaveNow) begin
            globalIrqEnable <= 1'b1;
        end else if (stackWr) begin
            globalIrqEnable <= wrByte[tsic_pkg::BIT_GIE];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            inService <= 1'b0;
        end else if (enterNow) begin
            inService <= 1'b1;
        end else if (leaveNow) begin
            inService <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            resumeStb <= 1'b0;
            popAddr   <= 12'h000;
        end else begin
            resumeStb <= leaveNow;
            if (leaveNow) begin
                popAddr <= retStack[stackLevel];
            end
        end
    end

    // ==================================================================
    // Restore strobe from the single save level
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            restoreStb       <= 1'b0;
            accRestore       <= 8'h00;
            procFlagsRestore <= 8'h00;
        end else begin
            restoreStb <= ctrlWr && wrByte[tsic_pkg::CTRL_RESTORE];
            if (ctrlWr && wrByte[tsic_pkg::CTRL_RESTORE]) begin
                accRestore       <= accSaved;
                procFlagsRestore <= flagsSaved;
            end
        end
    end
endmodule // tsic_irq_ctrl

// [tb/tsic_irq_ctrl_asserts.sv]
/*
 Checker on the ports of the interrupt controller top.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module tsic_irq_ctrl_asserts (
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic        instrBoundary,
    input wire logic        retiExec,
    input wire logic        takeIrq,
    input wire logic [11:0] vectorAddr,
    input wire logic        resumeStb,
    input wire logic        powerDown,
    input wire logic        wakeStb,
    input wire logic        restoreStb
);
    // ==================================================================
    // Service tracking
    logic inSvc;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    always_ff @(posedge clk_sys) begin
        if (!resetn)
            inSvc <= 1'b0;
        else if (takeIrq)
            inSvc <= 1'b1;
        else if (resumeStb)
            inSvc <= 1'b0;
    end
    // ==================================================================
    // Properties
    property p_vec; vectorAddr == 12'h008; endproperty
    a_vec: assert property (p_vec) else $error("vector address wrong");
    property p_once; takeIrq |-> !inSvc ##1 !takeIrq; endproperty
    a_once: assert property (p_once) else $error("entry during service");
    property p_exit; resumeStb |-> inSvc ##1 !resumeStb; endproperty
    a_exit: assert property (p_exit) else $error("return outside service");
    property p_bound; takeIrq |-> $past(instrBoundary); endproperty
    a_bound: assert property (p_bound) else $error("entry off boundary");
    property p_cause; resumeStb |-> $past(retiExec || avs_write); endproperty
    a_cause: assert property (p_cause) else $error("return without cause");
    property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_wait: assert property (p_wait) else $error("access not answered");
    property p_ack; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_ack: assert property (p_ack) else $error("answer too long");
    property p_wake; wakeStb |-> $past(powerDown) ##1 !powerDown; endproperty
    a_wake: assert property (p_wake) else $error("wake without sleep");
    property p_sleep; powerDown && $past(powerDown) |-> !takeIrq; endproperty
    a_sleep: assert property (p_sleep) else $error("entry while asleep");
    c_take: cover property (takeIrq);
    c_res: cover property (resumeStb);
    c_wake: cover property (wakeStb);
    c_rest: cover property (restoreStb);
endmodule // tsic_irq_ctrl_asserts

// [tb/tsic_core_model.sv]
/*
 Behavioural processor core facing the interrupt controller.
 Assumes the bench asks for a return from service through retiReq.
*/
`timescale 1ns/10ps
module tsic_core_model #(
    parameter int SLOW = 1
) (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        retiReq,
    output logic             instrBoundary,
    output logic             retiExec,
    output logic      [11:0] returnAddr
);
    // ==================================================================
    // Instruction stream
    logic [1:0] phase;
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            phase <= 2'h0;
            instrBoundary <= 1'b0;
            retiExec <= 1'b0;
            returnAddr <= 12'h100;
        end else begin
            phase <= phase + 2'h1;
            instrBoundary <= (SLOW == 0) || (phase == 2'h3);
            retiExec <= retiReq;
            if (retiReq)
                returnAddr <= returnAddr + 12'h011;
        end
    end
endmodule // tsic_core_model

// [tb/tsic_irq_ctrl_tb_top.sv]
/*
 Bench: registers over Avalon-MM, timer pulses, pin edges, entry and
 return, save buffer, sleep and wake. Assumes the core model and checker.
*/
`timescale 1ns/10ps
module tsic_irq_ctrl_tb_top;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic [9:0]  avs_address = '0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        extIrqInput = 1'b1;
    logic        timerAOverflow = 1'b0;
    logic        timerBOverflow = 1'b0;
    logic        retiReq = 1'b0;
    logic        instrBoundary, retiExec, takeIrq, resumeStb, powerDown, wakeStb, restoreStb;
    logic [11:0] returnAddr, vectorAddr, popAddr, takeRet, lastPop;
    logic [7:0]  accIn = '0;
    logic [7:0]  procFlagsIn = '0;
    logic [7:0]  accRestore, procFlagsRestore, lastAcc, lastFlags, rd;
    int          n_fail = 0;
    int          n_tests = 0;
    int          nTake = 0;
    int          nWake = 0;
    always #5 clk_sys = ~clk_sys;
    tsic_irq_ctrl i_dut (.clk_sys, .resetn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
        .extIrqInput, .timerAOverflow, .timerBOverflow, .instrBoundary, .retiExec,
        .returnAddr, .accIn, .procFlagsIn, .takeIrq, .vectorAddr, .popAddr, .resumeStb,
        .powerDown, .wakeStb, .accRestore, .procFlagsRestore, .restoreStb);
    tsic_core_model i_core (.clk_sys, .resetn, .retiReq, .instrBoundary, .retiExec,
        .returnAddr);
    // ==================================================================
    // Monitor
    always @(posedge clk_sys) begin
        if (takeIrq === 1'b1) begin
            nTake++;
            takeRet = returnAddr;
        end
        if (resumeStb === 1'b1)
            lastPop = popAddr;
        if (wakeStb === 1'b1)
            nWake++;
        if (restoreStb === 1'b1) begin
            lastAcc = accRestore;
            lastFlags = procFlagsRestore;
        end
    end
    // ==================================================================
    // Tasks
    task automatic conclude;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        avs_address <= {idx, 2'b00};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, wd};
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            conclude();
        end
        @(posedge clk_sys);
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk($sformatf("reg %h", idx), {4'h0, exp}, {4'h0, rd});
    endtask
    task automatic pin(input logic v);
        extIrqInput <= v;
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic pulse(input logic b);
        timerAOverflow <= !b;
        timerBOverflow <= b;
        @(posedge clk_sys);
        timerAOverflow <= 1'b0;
        timerBOverflow <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic return_from_irq;
        retiReq <= 1'b1;
        @(posedge clk_sys);
        retiReq <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic waitTake(input int want);
        for (int i = 0; i < 40 && nTake < want; i++)
            @(posedge clk_sys);
        chk("takes", want[11:0], nTake[11:0]);
    endtask
    // ==================================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        rdchk(tsic_pkg::IDX_EDGE_SELECT, tsic_pkg::RST_EDGE_SELECT);
        rdchk(tsic_pkg::IDX_IRQ_ENABLE, 8'h00);
        rdchk(tsic_pkg::IDX_IRQ_REQUEST, 8'h00);
        rdchk(tsic_pkg::IDX_STACK_GIE, 8'h03);
        rdchk(8'h20, 8'h00);
        bus(1'b1, tsic_pkg::IDX_IRQ_ENABLE, 8'hff);
        rdchk(tsic_pkg::IDX_IRQ_ENABLE, 8'h31);
        bus(1'b1, tsic_pkg::IDX_IRQ_ENABLE, 8'h00);
        bus(1'b1, tsic_pkg::IDX_STACK_GIE, 8'h82);
        pulse(1'b0);
        rdchk(tsic_pkg::IDX_IRQ_REQUEST, 8'h10);
        pulse(1'b1);
        rdchk(tsic_pkg::IDX_IRQ_REQUEST, 8'h30);
        pin(1'b0);
        pin(1'b1);
        rdchk(tsic_pkg::IDX_IRQ_REQUEST, 8'h31);
        waitTake(0);
        bus(1'b1, tsic_pkg::IDX_IRQ_ENABLE, 8'h20);
        waitTake(1);
        rdchk(tsic_pkg::IDX_STACK_GIE, 8'h03);
        rdchk(tsic_pkg::IDX_IRQ_REQUEST, 8'h31);
        bus(1'b1, tsic_pkg::IDX_IRQ_REQUEST, 8'h00);
        return_from_irq();
        chk("pop", takeRet, lastPop);
        rdchk(tsic_pkg::IDX_STACK_GIE, 8'h82);
        bus(1'b1, tsic_pkg::IDX_IRQ_ENABLE, 8'h00);
        for (int e = 0; e < 4; e++) begin
            bus(1'b1, tsic_pkg::IDX_EDGE_SELECT, {3'h0, e[1:0], 3'h0});
            bus(1'b1, tsic_pkg::IDX_IRQ_REQUEST, 8'h00);
            pin(1'b0);
            rdchk(tsic_pkg::IDX_IRQ_REQUEST, {7'h0, e[1]});
            bus(1'b1, tsic_pkg::IDX_IRQ_REQUEST, 8'h00);
            pin(1'b1);
            rdchk(tsic_pkg::IDX_IRQ_REQUEST, {7'h0, e[0]});
        end
        bus(1'b1, tsic_pkg::IDX_IRQ_REQUEST, 8'h00);
        bus(1'b1, tsic_pkg::IDX_IRQ_ENABLE, 8'h01);
        pin(1'b0);
        waitTake(2);
        bus(1'b1, tsic_pkg::IDX_IRQ_REQUEST, 8'h00);
        return_from_irq();
        bus(1'b1, tsic_pkg::IDX_IRQ_ENABLE, 8'h00);
        pin(1'b1);
        accIn <= 8'ha5;
        procFlagsIn <= 8'hff;
        bus(1'b1, tsic_pkg::IDX_CORE_CTRL, 8'h04);
        rdchk(tsic_pkg::IDX_SAVE_ACC, 8'ha5);
        rdchk(tsic_pkg::IDX_SAVE_FLAGS, tsic_pkg::MASK_FLAGS_SAVE);
        accIn <= 8'h00;
        bus(1'b1, tsic_pkg::IDX_CORE_CTRL, 8'h08);
        chk("restore", 12'h0a5, {4'h0, lastAcc});
        chk("restore flags", {4'h0, tsic_pkg::MASK_FLAGS_SAVE}, {4'h0, lastFlags});
        bus(1'b1, tsic_pkg::IDX_EDGE_SELECT, 8'h10);
        bus(1'b1, tsic_pkg::IDX_IRQ_REQUEST, 8'h00);
        bus(1'b1, tsic_pkg::IDX_IRQ_ENABLE, 8'h01);
        bus(1'b1, tsic_pkg::IDX_CORE_CTRL, 8'h10);
        chk("sleep", 12'h001, {11'h0, powerDown});
        pin(1'b0);
        chk("wake", 12'h001, nWake[11:0]);
        waitTake(3);
        rdchk(tsic_pkg::IDX_CORE_STATUS, 8'h01);
        bus(1'b1, tsic_pkg::IDX_IRQ_REQUEST, 8'h00);
        bus(1'b1, tsic_pkg::IDX_CORE_CTRL, 8'h02);
        rdchk(tsic_pkg::IDX_STACK_GIE, 8'h82);
        conclude();
    end
    initial begin
        #200000;
        n_fail++;
        conclude();
    end
endmodule // tsic_irq_ctrl_tb_top
bind tsic_irq_ctrl tsic_irq_ctrl_asserts i_chk (.clk_sys, .resetn, .avs_read, .avs_write,
    .avs_waitrequest, .instrBoundary, .retiExec, .takeIrq, .vectorAddr, .resumeStb,
    .powerDown, .wakeStb, .restoreStb);
